// File: hw/etc_tx_client_regs.vh
// Constants for the transmit client stream interface
`ifndef ETC_TX_CLIENT_REGS_VH
`define ETC_TX_CLIENT_REGS_VH
`define ETC_SEG_BYTES 8
`define ETC_SEG_BITS 64
`define ETC_MTY_W 3
`define ETC_WIDE_LANES 32
`define ETC_LANE_BITS 8
`define ETC_ERR_CTRL_BYTE 8'hFE
`define ETC_IDLE_BYTE 8'h07
`define ETC_SEL_SEG0 2'b01
`define ETC_SEL_SEG1 2'b10
`define ETC_ST_IDLE 2'b00
`define ETC_ST_FRAME 2'b01
`define ETC_ST_ABORT 2'b10
`define ETC_ZERO_MTY 3'h0
`endif

// File: hw/etc_seg_lane.v
// One 64-bit segment lane: byte masking and error word replacement
`include "etc_tx_client_regs.vh"
module etc_seg_lane
#(
   parameter SEG_BYTES = `ETC_SEG_BYTES
)
(
   input wire i_clk,
   input wire i_srst,
   input wire i_take,
   input wire [SEG_BYTES*8-1:0] i_data,
   input wire [SEG_BYTES-1:0] i_keep,
   input wire i_bad,
   output reg [SEG_BYTES*8-1:0] o_data,
   output reg [SEG_BYTES-1:0] o_keep,
   output reg o_ctrl
);
   integer b;
   reg [SEG_BYTES*8-1:0] data_next;
   always @*
   begin
      data_next = i_data;
      for (b = 0; b < SEG_BYTES; b = b + 1)
      begin
         // Empty lanes go out as idle so stale bytes never reach the line
         if (!i_keep[b])
         begin
            data_next[b*8 +: 8] = `ETC_IDLE_BYTE;
         end
         // Bad packet: last word becomes the error control code (see RQ13)
         if (i_bad)
         begin
            data_next[b*8 +: 8] = `ETC_ERR_CTRL_BYTE;
         end
      end
   end
   always @(posedge i_clk)
   begin
      if (i_srst)
      begin
         o_data <= {(SEG_BYTES*8){1'b0}};
         o_keep <= {SEG_BYTES{1'b0}};
         o_ctrl <= 1'b0;
      end
      else if (i_take)
      begin
         o_data <= data_next;
         o_keep <= i_bad ? {SEG_BYTES{1'b1}} : i_keep;
         o_ctrl <= i_bad;
      end
      else
      begin
         o_data <= {(SEG_BYTES*8){1'b0}};
         o_keep <= {SEG_BYTES{1'b0}};
         o_ctrl <= 1'b0;
      end
   end
endmodule

// File: hw/etc_tx_client.v
// Transmit client stream interface of a 40G/50G Ethernet MAC
`include "etc_tx_client_regs.vh"
// Behaviour
// RQ1 - Transmit clock output; all stream signals timed to it, 390.625/312.5 MHz.
// RQ2 - Ready high only when the interface can take data that cycle.
// RQ3 - User stops immediately on ready low; data offered then is ignored.
// RQ4 - Segment transfers only when its enable and valid are both high.
// RQ5 - Separate enable input for each of the two segments.
// RQ6 - User gives at most one frame start per bus cycle.
// RQ7 - User gives at most one frame end per bus cycle.
// RQ8 - Empty count N drops the last N bytes of the segment.
// RQ9 - User drives non-zero empty count only in the end cycle.
// RQ10 - Underflow output rises when data runs short mid-frame.
// RQ11 - User transfers every ready cycle until the frame's last word.
// RQ12 - Error input sampled only with segment enable and frame end.
// RQ13 - Sampled error replaces the final word with the error control code.
// RQ14 - Bad packet disables FCS checking and reporting for that packet.
// RQ15 - Optional 256-bit variant with last, keep and user signals.
// RQ16 - Wide variant signals sampled and driven on the rising clock edge.
// RQ17 - Surroundings supply a stable free-running configuration clock.
// RQ18 - Resets active high, synchronous, held until the clock is stable.
// RQ19 - Resets are synchronised inside the device.
// RQ20 - Wide user bit one marks bad packet, zero good.
// RQ21 - Wide last marks packet end; 32-bit keep qualifies bytes.
// RQ22 - Lane n is bits 8n+7:8n, qualified by keep bit n.
// RQ23 - User holds data and control while ready is low.
// RQ24 - Valid dropped before last is an implicit underrun aborting the frame.
// RQ25 - Each narrow segment is 64 bits, 8 bytes.
// RQ26 - Lane 13 occupies bits 111:104.
// RQ27 - Segment 0 carries earlier bytes, each segment LSB first.
module etc_tx_client
#(
   parameter WIDE_MODE = 0,
   parameter SEG_BYTES = `ETC_SEG_BYTES,
   parameter WIDE_LANES = `ETC_WIDE_LANES
)
(
   input wire I_REF_CLK,
   input wire I_SRST,
   input wire I_RX_SRST,
   input wire I_DCLK,
   input wire I_LINE_READY,
   output wire O_TX_CLK,
   output wire O_TX_READY,
   input wire I_TX_VALID,
   input wire [SEG_BYTES*16-1:0] I_TX_DATA,
   input wire I_SEGMENT0_TRANSFER_ENABLE,
   input wire I_SEGMENT1_TRANSFER_ENABLE,
   input wire I_SEGMENT0_FRAME_START,
   input wire I_SEGMENT1_FRAME_START,
   input wire I_SEGMENT0_FRAME_END,
   input wire I_SEGMENT1_FRAME_END,
   input wire [`ETC_MTY_W-1:0] I_SEGMENT0_EMPTY_COUNT,
   input wire [`ETC_MTY_W-1:0] I_SEGMENT1_EMPTY_COUNT,
   input wire I_SEGMENT0_PACKET_BAD,
   input wire I_SEGMENT1_PACKET_BAD,
   input wire [WIDE_LANES*8-1:0] I_WIDE_DATA,
   input wire [WIDE_LANES-1:0] I_WIDE_KEEP,
   input wire I_WIDE_LAST,
   input wire I_WIDE_USER,
   output reg O_UNDERFLOW,
   output wire [SEG_BYTES*16-1:0] O_LINE_DATA,
   output wire [SEG_BYTES*2-1:0] O_LINE_KEEP,
   output wire [1:0] O_LINE_CTRL,
   output reg [WIDE_LANES*8-1:0] O_WIDE_LINE_DATA,
   output reg [WIDE_LANES-1:0] O_WIDE_LINE_KEEP,
   output reg O_LINE_START,
   output reg O_LINE_END,
   output reg O_FCS_SUPPRESS
);
   // ****************************************************************
   // Reset synchronisation and clock
   // ****************************************************************
   // Resets are pipelined into this domain so callers need no synchroniser
   reg [1:0] tx_rst_sync_reg;
   reg [1:0] rx_rst_sync_reg;
   wire rst;
   always @(posedge I_REF_CLK)
   begin
      tx_rst_sync_reg <= {tx_rst_sync_reg[0], I_SRST}; // see RQ19
      rx_rst_sync_reg <= {rx_rst_sync_reg[0], I_RX_SRST}; // see RQ19
   end
   // Raw input also resets at once so outputs are defined from the first edge
   assign rst = I_SRST | tx_rst_sync_reg[1]; // see RQ18
   // The stream clock is the transmit clock; I_DCLK is only a stable reference
   assign O_TX_CLK = I_REF_CLK; // see RQ1 RQ16
   // ****************************************************************
   // Acceptance
   // ****************************************************************
   reg [1:0] state_reg;
   reg [1:0] state_next;
   wire ready;
   assign ready = ~rst & I_LINE_READY & (state_reg != `ETC_ST_ABORT);
   assign O_TX_READY = ready; // see RQ2
   // Offers during ready low are ignored (see RQ3)
   wire take0 = ready & I_TX_VALID & I_SEGMENT0_TRANSFER_ENABLE; // see RQ4 RQ5
   wire take1 = ready & I_TX_VALID & I_SEGMENT1_TRANSFER_ENABLE; // see RQ4 RQ5
   wire take_w = ready & I_TX_VALID;
   // ****************************************************************
   // Narrow variant byte keep from empty counts
   // ****************************************************************
   function [SEG_BYTES-1:0] keep_of;
      input [`ETC_MTY_W-1:0] mty;
      input eop;
      integer k;
      begin
         keep_of = {SEG_BYTES{1'b1}};
         // Only the end segment may shorten; stray counts earlier are ignored
         for (k = 0; k < SEG_BYTES; k = k + 1)
         begin
            if (eop && (k >= SEG_BYTES - mty))
            begin
               keep_of[k] = 1'b0; // see RQ8 RQ9
            end
         end
      end
   endfunction
   wire bad0 = take0 & I_SEGMENT0_FRAME_END & I_SEGMENT0_PACKET_BAD; // see RQ12
   wire bad1 = take1 & I_SEGMENT1_FRAME_END & I_SEGMENT1_PACKET_BAD; // see RQ12
   wire bad_w = take_w & I_WIDE_LAST & I_WIDE_USER; // see RQ20
   // Segment 0 is the lower 64 bits and precedes segment 1 (see RQ25 RQ27)
   genvar g;
   generate
      for (g = 0; g < 2; g = g + 1)
      begin : seg
         wire [`ETC_MTY_W-1:0] mty = g ? I_SEGMENT1_EMPTY_COUNT : I_SEGMENT0_EMPTY_COUNT;
         wire eop = g ? I_SEGMENT1_FRAME_END : I_SEGMENT0_FRAME_END;
         etc_seg_lane #(.SEG_BYTES(SEG_BYTES)) u_lane
         (
            .i_clk(I_REF_CLK),
            .i_srst(rst),
            .i_take((WIDE_MODE == 0) && (g ? take1 : take0)),
            .i_data(I_TX_DATA[g*SEG_BYTES*8 +: SEG_BYTES*8]),
            .i_keep(keep_of(mty, eop)),
            .i_bad(g ? bad1 : bad0), // see RQ13
            .o_data(O_LINE_DATA[g*SEG_BYTES*8 +: SEG_BYTES*8]),
            .o_keep(O_LINE_KEEP[g*SEG_BYTES +: SEG_BYTES]),
            .o_ctrl(O_LINE_CTRL[g])
         );
      end
   endgenerate
   // ****************************************************************
   // Wide variant, 32 byte lanes
   // ****************************************************************
   integer n;
   reg [WIDE_LANES*8-1:0] wide_next;
   always @*
   begin
      wide_next = I_WIDE_DATA;
      for (n = 0; n < WIDE_LANES; n = n + 1)
      begin
         // Lane n is bits 8n+7:8n, lane 13 at 111:104 (see RQ22 RQ26)
         if (!I_WIDE_KEEP[n])
         begin
            wide_next[n*`ETC_LANE_BITS +: `ETC_LANE_BITS] = `ETC_IDLE_BYTE;
         end
         if (bad_w)
         begin
            wide_next[n*`ETC_LANE_BITS +: `ETC_LANE_BITS] = `ETC_ERR_CTRL_BYTE; // see RQ13
         end
      end
   end
   always @(posedge I_REF_CLK)
   begin
      if (rst)
      begin
         O_WIDE_LINE_DATA <= {(WIDE_LANES*8){1'b0}};
         O_WIDE_LINE_KEEP <= {WIDE_LANES{1'b0}};
      end
      else if ((WIDE_MODE != 0) && take_w)
      begin
         O_WIDE_LINE_DATA <= wide_next; // see RQ15 RQ21
         O_WIDE_LINE_KEEP <= bad_w ? {WIDE_LANES{1'b1}} : I_WIDE_KEEP;
      end
      else
      begin
         O_WIDE_LINE_DATA <= {(WIDE_LANES*8){1'b0}};
         O_WIDE_LINE_KEEP <= {WIDE_LANES{1'b0}};
      end
   end
   // ****************************************************************
   // Frame tracking and underflow
   // ****************************************************************
   wire sop_in = (WIDE_MODE != 0) ? take_w
      : ((take0 & I_SEGMENT0_FRAME_START) | (take1 & I_SEGMENT1_FRAME_START));
   wire eop_in = (WIDE_MODE != 0) ? (take_w & I_WIDE_LAST)
      : ((take0 & I_SEGMENT0_FRAME_END) | (take1 & I_SEGMENT1_FRAME_END));
   wire bad_in = (WIDE_MODE != 0) ? bad_w : (bad0 | bad1);
   // A frame may end in segment 0 while the next one starts in segment 1
   wire reopen = (WIDE_MODE == 0) & take0 & I_SEGMENT0_FRAME_END
      & take1 & I_SEGMENT1_FRAME_START; // see RQ6 RQ7
   // A ready cycle without data inside a frame starves the line
   wire starve = ready & ~I_TX_VALID; // see RQ10 RQ24
   always @*
   begin
      state_next = state_reg;
      case (state_reg)
         `ETC_ST_IDLE:
         begin
            if (sop_in && (!eop_in || reopen))
            begin
               state_next = `ETC_ST_FRAME;
            end
         end
         `ETC_ST_FRAME:
         begin
            if (reopen)
            begin
               state_next = `ETC_ST_FRAME;
            end
            else if (eop_in)
            begin
               state_next = `ETC_ST_IDLE;
            end
            else if (starve)
            begin
               state_next = `ETC_ST_ABORT; // see RQ24
            end
         end
         `ETC_ST_ABORT:
         begin
            // One dead cycle lets the line close the broken frame
            state_next = `ETC_ST_IDLE;
         end
         default:
         begin
            state_next = `ETC_ST_IDLE;
         end
      endcase
   end
   always @(posedge I_REF_CLK)
   begin
      if (rst)
      begin
         state_reg <= `ETC_ST_IDLE;
         O_UNDERFLOW <= 1'b0;
         O_LINE_START <= 1'b0;
         O_LINE_END <= 1'b0;
         O_FCS_SUPPRESS <= 1'b0;
      end
      else
      begin
         state_reg <= state_next;
         O_UNDERFLOW <= (state_reg == `ETC_ST_FRAME) && starve && !eop_in; // see RQ10
         O_LINE_START <= sop_in && ((state_reg == `ETC_ST_IDLE) || reopen);
         O_LINE_END <= eop_in;
         O_FCS_SUPPRESS <= bad_in; // see RQ14
      end
   end
endmodule

// File: test/etc_tx_client_sva.sv
// Port assertions for the narrow transmit client stream
module etc_tx_client_sva
#(
   parameter SEG_BYTES = 8,
   parameter WIDE_MODE = 0
)
(
   input wire I_REF_CLK,
   input wire I_SRST,
   input wire I_LINE_READY,
   input wire O_TX_READY,
   input wire I_TX_VALID,
   input wire [SEG_BYTES*16-1:0] I_TX_DATA,
   input wire I_SEGMENT0_TRANSFER_ENABLE,
   input wire I_SEGMENT1_TRANSFER_ENABLE,
   input wire I_SEGMENT0_FRAME_START,
   input wire I_SEGMENT0_FRAME_END,
   input wire I_SEGMENT1_FRAME_END,
   input wire [2:0] I_SEGMENT1_EMPTY_COUNT,
   input wire I_SEGMENT1_PACKET_BAD,
   input wire O_UNDERFLOW,
   input wire [SEG_BYTES*16-1:0] O_LINE_DATA,
   input wire [SEG_BYTES*2-1:0] O_LINE_KEEP,
   input wire [1:0] O_LINE_CTRL,
   input wire O_LINE_START,
   input wire O_FCS_SUPPRESS
);
   timeunit 1ns;
   timeprecision 100ps;
   wire tk = I_TX_VALID & O_TX_READY;
   wire tk0 = tk & I_SEGMENT0_TRANSFER_ENABLE;
   wire end1 = tk & I_SEGMENT1_TRANSFER_ENABLE & I_SEGMENT1_FRAME_END;
   default clocking @(posedge I_REF_CLK); endclocking
   default disable iff (I_SRST);
   chk_ready_line: assert property (!I_LINE_READY |-> !O_TX_READY)
      else $error("ready without line");
   chk_idle_quiet: assert property (!tk |=> O_LINE_KEEP == 16'h0 && !O_LINE_START)
      else $error("output without transfer");
   chk_start_out: assert property (tk0 && I_SEGMENT0_FRAME_START |=> O_LINE_START)
      else $error("start lost");
   chk_seg0_data: assert property (tk0 && !I_SEGMENT0_FRAME_END |=>
      O_LINE_DATA[63:0] == $past(I_TX_DATA[63:0]) && O_LINE_KEEP[7:0] == 8'hFF)
      else $error("segment 0 word wrong");
   chk_seg1_gate: assert property (tk && !I_SEGMENT1_TRANSFER_ENABLE |=> O_LINE_KEEP[15:8] == 8'h0)
      else $error("disabled segment passed");
   chk_empty_keep: assert property (end1 && !I_SEGMENT1_PACKET_BAD |=>
      O_LINE_KEEP[15:8] == 8'hFF >> $past(I_SEGMENT1_EMPTY_COUNT))
      else $error("empty count ignored");
   chk_bad_word: assert property (end1 && I_SEGMENT1_PACKET_BAD |=>
      O_LINE_CTRL[1] && O_FCS_SUPPRESS && O_LINE_DATA[127:64] == {8{8'hFE}})
      else $error("bad end not marked");
   chk_err_masked: assert property ((WIDE_MODE == 0) && tk && !I_SEGMENT0_FRAME_END
      && !end1 |=> O_LINE_CTRL == 2'h0 && !O_FCS_SUPPRESS)
      else $error("error taken outside end");
   chk_under_why: assert property ($rose(O_UNDERFLOW) |-> $past(!I_TX_VALID && O_TX_READY))
      else $error("underflow without cause");
   chk_under_abort: assert property (O_UNDERFLOW |-> !O_TX_READY ##1 !O_UNDERFLOW)
      else $error("abort not taken");
   cover property (end1 && I_SEGMENT1_PACKET_BAD);
   cover property (O_UNDERFLOW);
   cover property (tk0 && I_SEGMENT0_FRAME_START);
endmodule
bind etc_tx_client etc_tx_client_sva #(.SEG_BYTES(SEG_BYTES), .WIDE_MODE(WIDE_MODE)) chk
(
   .I_REF_CLK(I_REF_CLK), .I_SRST(I_SRST), .I_LINE_READY(I_LINE_READY),
   .O_TX_READY(O_TX_READY), .I_TX_VALID(I_TX_VALID), .I_TX_DATA(I_TX_DATA),
   .I_SEGMENT0_TRANSFER_ENABLE(I_SEGMENT0_TRANSFER_ENABLE),
   .I_SEGMENT1_TRANSFER_ENABLE(I_SEGMENT1_TRANSFER_ENABLE),
   .I_SEGMENT0_FRAME_START(I_SEGMENT0_FRAME_START), .I_SEGMENT0_FRAME_END(I_SEGMENT0_FRAME_END),
   .I_SEGMENT1_FRAME_END(I_SEGMENT1_FRAME_END), .I_SEGMENT1_EMPTY_COUNT(I_SEGMENT1_EMPTY_COUNT),
   .I_SEGMENT1_PACKET_BAD(I_SEGMENT1_PACKET_BAD), .O_UNDERFLOW(O_UNDERFLOW),
   .O_LINE_DATA(O_LINE_DATA), .O_LINE_KEEP(O_LINE_KEEP), .O_LINE_CTRL(O_LINE_CTRL),
   .O_LINE_START(O_LINE_START), .O_FCS_SUPPRESS(O_FCS_SUPPRESS)
);

// File: test/etc_tx_src.sv
// User-side frame source driving the narrow stream
module etc_tx_src
(
   input wire i_clk,
   input wire i_ready,
   output logic o_valid = 1'b0,
   output logic [127:0] o_data = 128'h0,
   output logic [1:0] o_ena = 2'h0,
   output logic [1:0] o_sop = 2'h0,
   output logic [1:0] o_eop = 2'h0,
   output logic [5:0] o_mty = 6'h0,
   output logic [1:0] o_bad = 2'h0
);
   timeunit 1ns;
   timeprecision 100ps;
   task automatic beat(input logic [127:0] d, input logic [1:0] en, sp, ep,
      input logic [5:0] m, input logic [1:0] b);
      bit r;
      r = 1'b0;
      o_valid = 1'b1;
      o_data = d;
      o_ena = en;
      o_sop = sp;
      o_eop = ep;
      o_mty = m;
      o_bad = b;
      // Word and sideband stay put until an edge with ready high
      while (!r)
      begin
         @(negedge i_clk);
         r = i_ready;
         @(posedge i_clk);
      end
      #1;
   endtask
   task automatic idle();
      o_valid = 1'b0;
      o_data = ~o_data;
      o_ena = 2'h0;
      o_sop = 2'h0;
      o_eop = 2'h0;
      o_mty = 6'h0;
      o_bad = 2'h0;
   endtask
endmodule

// File: test/etc_tx_client_tb_top.sv
// Self-checking bench for the transmit client stream
module etc_tx_client_tb_top;
   timeunit 1ns;
   timeprecision 100ps;
   localparam logic [127:0] D0 = 128'h0F0E_0D0C_0B0A_0908_0706_0504_0302_0100;
   localparam logic [127:0] D1 = 128'h1F1E_1D1C_1B1A_1918_1716_1514_1312_1110;
   logic clk = 1'b0;
   logic srst = 1'b1;
   logic line_rdy = 1'b1;
   wire rdy, valid, uf, lstart, lend, fcs;
   wire [127:0] data, ldata;
   wire [1:0] ena, sop, eop, bad, ctrl;
   wire [5:0] mty;
   wire [15:0] lkeep;
   wire txclk, w_rdy, w_uf, w_start, w_end, w_fcs;
   wire [255:0] wl_data;
   wire [31:0] wl_keep;
   logic dclk = 1'b0;
   logic wvalid = 1'b0;
   logic wlast = 1'b0;
   logic wuser = 1'b0;
   logic [255:0] wdata = 256'h0;
   logic [31:0] wkeep = 32'h0;
   int err_total = 0;
   int comparisons = 0;
   int cyc = 0;
   always #25 clk = ~clk;
   // Free-running configuration clock near 75 MHz
   always #6.7 dclk = ~dclk;
   etc_tx_src src (.i_clk(clk), .i_ready(rdy), .o_valid(valid), .o_data(data), .o_ena(ena),
      .o_sop(sop), .o_eop(eop), .o_mty(mty), .o_bad(bad));
   etc_tx_client dut
   (
      .I_REF_CLK(clk), .I_SRST(srst), .I_RX_SRST(srst), .I_DCLK(dclk), .I_LINE_READY(line_rdy),
      .O_TX_CLK(txclk), .O_TX_READY(rdy), .I_TX_VALID(valid), .I_TX_DATA(data),
      .I_SEGMENT0_TRANSFER_ENABLE(ena[0]), .I_SEGMENT1_TRANSFER_ENABLE(ena[1]),
      .I_SEGMENT0_FRAME_START(sop[0]), .I_SEGMENT1_FRAME_START(sop[1]),
      .I_SEGMENT0_FRAME_END(eop[0]), .I_SEGMENT1_FRAME_END(eop[1]),
      .I_SEGMENT0_EMPTY_COUNT(mty[2:0]), .I_SEGMENT1_EMPTY_COUNT(mty[5:3]),
      .I_SEGMENT0_PACKET_BAD(bad[0]), .I_SEGMENT1_PACKET_BAD(bad[1]), .I_WIDE_DATA(256'h0),
      .I_WIDE_KEEP(32'h0), .I_WIDE_LAST(1'b0), .I_WIDE_USER(1'b0), .O_UNDERFLOW(uf),
      .O_LINE_DATA(ldata), .O_LINE_KEEP(lkeep), .O_LINE_CTRL(ctrl), .O_WIDE_LINE_DATA(),
      .O_WIDE_LINE_KEEP(), .O_LINE_START(lstart), .O_LINE_END(lend), .O_FCS_SUPPRESS(fcs)
   );
   // Second copy built for the 256-bit stream
   etc_tx_client #(.WIDE_MODE(1)) dut_wide
   (
      .I_REF_CLK(clk), .I_SRST(srst), .I_RX_SRST(srst), .I_DCLK(dclk), .I_LINE_READY(line_rdy),
      .O_TX_CLK(), .O_TX_READY(w_rdy), .I_TX_VALID(wvalid), .I_TX_DATA(128'h0),
      .I_SEGMENT0_TRANSFER_ENABLE(1'b0), .I_SEGMENT1_TRANSFER_ENABLE(1'b0),
      .I_SEGMENT0_FRAME_START(1'b0), .I_SEGMENT1_FRAME_START(1'b0),
      .I_SEGMENT0_FRAME_END(1'b0), .I_SEGMENT1_FRAME_END(1'b0),
      .I_SEGMENT0_EMPTY_COUNT(3'h0), .I_SEGMENT1_EMPTY_COUNT(3'h0),
      .I_SEGMENT0_PACKET_BAD(1'b0), .I_SEGMENT1_PACKET_BAD(1'b0), .I_WIDE_DATA(wdata),
      .I_WIDE_KEEP(wkeep), .I_WIDE_LAST(wlast), .I_WIDE_USER(wuser), .O_UNDERFLOW(w_uf),
      .O_LINE_DATA(), .O_LINE_KEEP(), .O_LINE_CTRL(), .O_WIDE_LINE_DATA(wl_data),
      .O_WIDE_LINE_KEEP(wl_keep), .O_LINE_START(w_start), .O_LINE_END(w_end),
      .O_FCS_SUPPRESS(w_fcs)
   );
   task automatic cmp(input logic [255:0] got, exp);
      comparisons++;
      if (got !== exp)
      begin
         err_total++;
         $display("unexpected at %0t: got %h expected %h", $time, got, exp);
      end
   endtask
   task automatic stop_test();
      $display("comparisons %0d mismatches %0d", comparisons, err_total);
      if (err_total == 0 && comparisons > 0)
         $display("ALL CHECKS OK");
      else
         $display("CHECKS NOT OK");
      $finish;
   endtask
   // A hang must not eat the whole run
   always @(posedge clk)
   begin
      cyc++;
      if (cyc == 400)
      begin
         err_total++;
         stop_test();
      end
   end
   // Wide beat: word and sideband stay put until an edge with ready high
   task automatic wbeat(input logic [255:0] d, input logic [31:0] k, input logic l, u);
      bit r;
      r = 1'b0;
      wvalid = 1'b1;
      wdata = d;
      wkeep = k;
      wlast = l;
      wuser = u;
      while (!r)
      begin
         @(negedge clk);
         r = w_rdy;
         @(posedge clk);
      end
      #1;
   endtask
   task automatic t_wide();
      wbeat({D1, D0}, 32'hFFFF_FFFF, 1'b0, 1'b0);
      cmp({w_uf, w_rdy, w_start, wl_keep}, {3'b011, 32'hFFFF_FFFF});
      cmp(wl_data, {D1, D0});
      wbeat({D0, D1}, 32'h0000_3FFF, 1'b1, 1'b0);
      cmp({w_end, w_fcs, wl_keep}, {2'b10, 32'h0000_3FFF});
      cmp(wl_data, {{18{8'h07}}, D1[111:0]});
      cmp(wl_data[111:104], 8'h1D);
      wbeat({D1, D0}, 32'h0000_0001, 1'b1, 1'b1);
      cmp({w_start, w_end, w_fcs, wl_keep}, {3'b111, 32'hFFFF_FFFF});
      cmp(wl_data, {32{8'hFE}});
      wvalid = 1'b0;
      $display("t_wide done");
   endtask
   task automatic t_frame();
      src.beat(D0, 2'b11, 2'b01, 2'b00, 6'h00, 2'b00);
      cmp(lstart, 1'b1);
      cmp({lkeep, ldata}, {16'hFFFF, D0});
      src.beat(D1, 2'b11, 2'b00, 2'b10, 6'h10, 2'b00);
      cmp({lend, fcs, lkeep}, {2'b10, 16'h3FFF});
      cmp(ldata, {16'h0707, D1[111:0]});
      $display("t_frame done");
   endtask
   task automatic t_bad();
      src.beat(D1, 2'b01, 2'b01, 2'b00, 6'h00, 2'b01);
      cmp({ctrl, fcs, lkeep}, {3'b000, 16'h00FF});
      src.beat(D0, 2'b11, 2'b00, 2'b10, 6'h18, 2'b10);
      cmp({ctrl, fcs, lkeep}, {3'b101, 16'hFFFF});
      cmp(ldata, {{8{8'hFE}}, D0[63:0]});
      $display("t_bad done");
   endtask
   task automatic t_under();
      src.beat(D0, 2'b11, 2'b01, 2'b00, 6'h00, 2'b00);
      src.idle();
      @(posedge clk);
      #1;
      cmp({uf, rdy}, 2'b10);
      @(posedge clk);
      #1;
      cmp({uf, rdy}, 2'b01);
      $display("t_under done");
   endtask
   task automatic t_stall();
      line_rdy = 1'b0;
      fork
         src.beat(D1, 2'b01, 2'b01, 2'b00, 6'h00, 2'b00);
         begin
            @(posedge clk);
            #1;
            cmp({rdy, lstart, lkeep}, 18'h0);
            line_rdy = 1'b1;
         end
      join
      cmp(lstart, 1'b1);
      src.beat(D0, 2'b01, 2'b00, 2'b01, 6'h07, 2'b00);
      cmp({lend, lkeep}, {1'b1, 16'h0001});
      cmp(ldata, {64'h0, 56'h07_0707_0707_0707, D0[7:0]});
      src.idle();
      $display("t_stall done");
   endtask
   initial
   begin
      repeat (2) @(posedge clk);
      #1 srst = 1'b0;
      repeat (4) @(posedge clk);
      #1;
      cmp(rdy, 1'b1);
      cmp(txclk, 1'b1);
      t_frame();
      t_bad();
      t_under();
      t_stall();
      t_wide();
      stop_test();
   end
endmodule
